// ===== core/aof_output_formatter.sv
// module: sample formatter and output driver control for a 14-bit converter
//
// How it works
// - three output modes: full-rate cmos, ddr cmos, ddr lvds, by register or strap
// - strap configuration offers full-rate cmos or ddr lvds only
// - full-rate cmos puts all 14 bits on own lines with flag and clocks
// - ddr cmos carries two bits per line on seven lines
// - ddr lvds carries two bits per pair on seven pairs
// - lvds current defaults 3.5mA, seven selectable levels 1.75mA to 4.5mA
// - internal termination on raises lvds drive current by 1.6x
// - overrange flag high when input beyond either range end
// - overrange flag travels through the same pipeline as the sample
// - full-rate data changes with falling edge of true forwarded clock
// - double-rate data changes on both forwarded clock edges
// - forwarded clock delayed 0, 45, 90 or 135 degrees by clock control with stabilizer on
// - separate bit inverts both clock lines, giving 0 to 315 degrees
// - offset binary after reset; format bit selects two's complement
// - midscale 10 0000..., two's complement flips top bit, saturate overrange
// - randomizer xors every bit above lsb with the lsb
// - alternate polarity inverts odd bits only
// - randomizer and alternate polarity enabled independently, any combination
// - alternate polarity forces offset binary, ignoring two's complement bit
// - ddr line carries even bit while clock low, odd while high
// - strap low selects full-rate cmos; high selects ddr lvds 3.5mA, no termination
module aof_output_formatter (
  input wire logic mclk, // encode clock
  input wire logic reset_n, // synchronous reset
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [aof_pkg::ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic config_style_strap, // high: strap (parallel) configuration
  input wire logic mode_strap, // output mode strap
  input wire logic [aof_pkg::SAMPLE_W-1:0] core_code, // raw offset binary code
  input wire logic core_over, // input above range
  input wire logic core_under, // input below range
  output logic core_take, // high in the cycle the core sample is taken
  output logic [aof_pkg::SAMPLE_W-1:0] sample_bits, // data lines
  output logic overrange_flag, // overrange flag line
  output logic forwarded_data_clock_p, // true forwarded clock
  output logic forwarded_data_clock_n, // complement forwarded clock
  output logic [1:0] out_mode, // active output mode code
  output logic [12:0] lvds_drive_ua, // lvds driver current, microamps
  output logic lvds_term_en, // internal lvds termination on
  output logic dcs_enable // duty cycle stabilizer on
);

  // ==========================================================
  // declarations
  logic [2:0] ph;
  logic [2:0] next_ph;
  logic boundary;
  logic par_s1, par_s2, md_s1, md_s2;
  logic [7:0] clock_control_register;
  logic [7:0] output_mode_register;
  logic [7:0] formatting_register;
  logic wb_req;
  logic wb_wr_commit;
  logic [31:0] rd_data;
  aof_pkg::aof_cfg_s cfg;
  aof_pkg::aof_word_s next_word;
  aof_pkg::aof_word_s word;
  aof_pkg::aof_word_s cur;
  logic [2:0] clk_shift;
  logic [2:0] clk_rel;

  // even bits of each pair, low half of the period
  function automatic logic [aof_pkg::PAIRS-1:0] even_bits(input logic [13:0] c);
    logic [aof_pkg::PAIRS-1:0] r;
    r = '0;
    for (int i = 0; i < aof_pkg::PAIRS; i++) begin
      r[i] = c[2*i];
    end
    return r;
  endfunction

  // odd bits of each pair, high half of the period
  function automatic logic [aof_pkg::PAIRS-1:0] odd_bits(input logic [13:0] c);
    logic [aof_pkg::PAIRS-1:0] r;
    r = '0;
    for (int i = 0; i < aof_pkg::PAIRS; i++) begin
      r[i] = c[2*i+1];
    end
    return r;
  endfunction

  // ==========================================================
  // phase counter: eight phases make one sample period
  assign next_ph = ph + 3'h1;
  assign boundary = ce && (ph == aof_pkg::PH_LAST);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ph <= 3'h0;
    end else if (ce) begin
      ph <= next_ph;
    end
  end

  // strap pins pass two flip-flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      par_s1 <= 1'b0;
      par_s2 <= 1'b0;
      md_s1 <= 1'b0;
      md_s2 <= 1'b0;
    end else if (ce) begin
      par_s1 <= config_style_strap;
      par_s2 <= par_s1;
      md_s1 <= mode_strap;
      md_s2 <= md_s1;
    end
  end

  // ==========================================================
  // wishbone slave, one wait state, ack for one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge where the master sees ack, low byte lane only
  assign wb_wr_commit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else if (ce) begin
      wb_ack_o <= wb_req;
    end
  end

  // register writes, low byte lane only
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      clock_control_register <= aof_pkg::CLK_CTL_RST;
      output_mode_register <= aof_pkg::OUT_MODE_RST;
      formatting_register <= aof_pkg::FMT_RST;
    end else if (ce && wb_wr_commit) begin
      case (wb_adr_i)
        aof_pkg::CLK_CTL_OFS: clock_control_register <= wb_dat_i[7:0];
        aof_pkg::OUT_MODE_OFS: output_mode_register <= wb_dat_i[7:0];
        aof_pkg::FMT_OFS: formatting_register <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped reads return zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      aof_pkg::CLK_CTL_OFS: rd_data[7:0] = clock_control_register;
      aof_pkg::OUT_MODE_OFS: rd_data[7:0] = output_mode_register;
      aof_pkg::FMT_OFS: rd_data[7:0] = formatting_register;
      aof_pkg::STATUS_OFS: begin
        rd_data[aof_pkg::ST_MODE_LSB +: 2] = out_mode;
        rd_data[aof_pkg::ST_PAR_BIT] = par_s2;
        rd_data[aof_pkg::ST_OVR_BIT] = overrange_flag;
        rd_data[aof_pkg::ST_DCS_BIT] = dcs_enable;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce && wb_req) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_data;
    end
  end

  // ==========================================================
  // effective configuration from straps or registers
  always_comb begin
    cfg = '0;
    if (par_s2) begin
      // strap style: only full-rate cmos or lvds at default current
      cfg.mode = md_s2 ? aof_pkg::MODE_DDR_LVDS : aof_pkg::MODE_FULL_CMOS;
      cfg.cur_sel = aof_pkg::CUR_SEL_DEFAULT;
      cfg.term = 1'b0;
    end else begin
      case (output_mode_register[aof_pkg::OM_MODE_LSB +: 2])
        aof_pkg::MODE_CODE_DDR_CMOS: cfg.mode = aof_pkg::MODE_DDR_CMOS;
        aof_pkg::MODE_CODE_DDR_LVDS: cfg.mode = aof_pkg::MODE_DDR_LVDS;
        default: cfg.mode = aof_pkg::MODE_FULL_CMOS;
      endcase
      cfg.cur_sel = output_mode_register[aof_pkg::OM_CUR_LSB +: 3];
      cfg.term = output_mode_register[aof_pkg::OM_TERM_BIT];
      // phase delay bits only honoured with the stabilizer on; the invert bit always applies
      if (clock_control_register[aof_pkg::CC_DCS_BIT]) begin
        cfg.shift[1:0] = clock_control_register[aof_pkg::CC_PHASE_LSB +: 2];
      end
      cfg.shift[2] = clock_control_register[aof_pkg::CC_INV_BIT];
      cfg.twos = formatting_register[aof_pkg::FM_TWOS_BIT];
      cfg.rnd = formatting_register[aof_pkg::FM_RAND_BIT];
      cfg.abp = formatting_register[aof_pkg::FM_ABP_BIT];
    end
  end

  // format the incoming sample: saturate, number format, xor, odd inversion
  always_comb begin
    next_word = '0;
    if (core_over) begin
      next_word.code = aof_pkg::CODE_TOP;
    end else if (core_under) begin
      next_word.code = aof_pkg::CODE_BOTTOM;
    end else begin
      next_word.code = core_code;
    end
    next_word.ovr = core_over || core_under;
    if (cfg.twos && !cfg.abp) begin
      next_word.code[13] = ~next_word.code[13];
    end
    if (cfg.rnd) begin
      next_word.code[13:1] = next_word.code[13:1] ^ {13{next_word.code[0]}};
    end
    if (cfg.abp) begin
      next_word.code = next_word.code ^ aof_pkg::ODD_MASK;
    end
    next_word.mode = cfg.mode;
    next_word.shift = cfg.shift;
    next_word.term = cfg.term;
    if (cfg.term) begin
      next_word.ua = 13'(({3'h0, aof_pkg::LVDS_UA[cfg.cur_sel]} * aof_pkg::TERM_MUL)
                         / aof_pkg::TERM_DIV);
    end else begin
      next_word.ua = aof_pkg::LVDS_UA[cfg.cur_sel];
    end
  end

  // ==========================================================
  // two-stage sample pipeline, advanced only at the sample boundary
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      word <= '0;
      cur <= '0;
      core_take <= 1'b0;
    end else if (ce) begin
      core_take <= (next_ph == aof_pkg::PH_LAST);
      if (boundary) begin
        word <= next_word;
        cur <= word;
      end
    end
  end

  // data lines: full rate once per sample, ddr twice
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sample_bits <= '0;
      overrange_flag <= 1'b0;
    end else if (ce) begin
      if (boundary) begin
        overrange_flag <= word.ovr;
        if (word.mode == aof_pkg::MODE_FULL_CMOS) begin
          sample_bits <= word.code;
        end else begin
          sample_bits <= {7'h00, even_bits(word.code)};
        end
      end else if (ph == aof_pkg::PH_MID && cur.mode != aof_pkg::MODE_FULL_CMOS) begin
        sample_bits <= {7'h00, odd_bits(cur.code)};
      end
    end
  end

  // forwarded clock: low in first half, delayed by the shift in 45 degree steps
  // a shift change between samples leaves one clock level shorter or longer than half a period
  assign clk_shift = boundary ? word.shift : cur.shift;
  assign clk_rel = next_ph - clk_shift;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      forwarded_data_clock_p <= 1'b0;
      forwarded_data_clock_n <= 1'b1;
    end else if (ce) begin
      forwarded_data_clock_p <= clk_rel[2];
      forwarded_data_clock_n <= ~clk_rel[2];
    end
  end

  // driver settings follow the sample on the lines
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      out_mode <= aof_pkg::MODE_CODE_FULL;
      lvds_drive_ua <= aof_pkg::LVDS_UA[aof_pkg::CUR_SEL_DEFAULT];
      lvds_term_en <= 1'b0;
      dcs_enable <= 1'b0;
    end else if (ce) begin
      dcs_enable <= !par_s2 && clock_control_register[aof_pkg::CC_DCS_BIT];
      if (boundary) begin
        out_mode <= 2'(word.mode);
        lvds_drive_ua <= word.ua;
        lvds_term_en <= word.term;
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_clk_pair: assert property (forwarded_data_clock_n == ~forwarded_data_clock_p)
    else $error("forwarded clock lines not complementary");

  a_clk_phase: assert property ($rose(forwarded_data_clock_p) |-> ph == 3'(4 + cur.shift))
    else $error("forwarded clock rises at wrong phase");

  a_full_hold: assert property (ce && ph != aof_pkg::PH_LAST
      && cur.mode == aof_pkg::MODE_FULL_CMOS |=> $stable(sample_bits))
    else $error("full-rate data changed inside a sample");

  a_ddr_even: assert property (cur.mode != aof_pkg::MODE_FULL_CMOS && ph < 3'h4
      |-> sample_bits[6:0] == even_bits(cur.code))
    else $error("ddr line not carrying even bit in low half");

  a_ddr_odd: assert property (cur.mode != aof_pkg::MODE_FULL_CMOS && ph >= 3'h4
      |-> sample_bits[6:0] == odd_bits(cur.code))
    else $error("ddr line not carrying odd bit in high half");

  a_flag_aligned: assert property (boundary ##1 ce [*8]
      |=> overrange_flag == $past(word.ovr, 8))
    else $error("overrange flag not aligned with its sample");

  a_sat_top: assert property (boundary && core_over && !cfg.rnd && !cfg.abp
      |=> word.ovr && word.code == {~$past(cfg.twos), 13'h1fff})
    else $error("overrange did not saturate at top code");

  a_twos_top: assert property (boundary && cfg.twos && !cfg.abp && !cfg.rnd
      && !core_over && !core_under
      |=> word.code == {~$past(core_code[13]), $past(core_code[12:0])})
    else $error("twos complement did not flip the top bit");

  a_odd_invert: assert property (boundary && cfg.abp && !cfg.twos && !cfg.rnd
      && !core_over && !core_under
      |=> word.code == ($past(core_code) ^ aof_pkg::ODD_MASK))
    else $error("alternate polarity did not invert odd bits");

  a_abp_offset: assert property (boundary && cfg.abp && cfg.twos && !cfg.rnd
      && !core_over && !core_under
      |=> word.code == ($past(core_code) ^ aof_pkg::ODD_MASK))
    else $error("alternate polarity not offset binary");

  a_randomize: assert property (boundary && cfg.rnd && !cfg.abp && !cfg.twos
      && !core_over && !core_under
      |=> word.code == {$past(core_code[13:1]) ^ {13{$past(core_code[0])}},
                        $past(core_code[0])})
    else $error("randomizer output wrong");

  a_strap_mode: assert property (boundary && par_s2
      |=> word.mode == (md_s2 ? aof_pkg::MODE_DDR_LVDS : aof_pkg::MODE_FULL_CMOS)
          && !word.term)
    else $error("strap mode selection wrong");

  a_term_boost: assert property (lvds_term_en && out_mode == aof_pkg::MODE_CODE_DDR_LVDS
      |-> lvds_drive_ua > 13'h0aaf)
    else $error("termination did not raise drive current");

  c_ddr_lvds: cover property (boundary && cfg.mode == aof_pkg::MODE_DDR_LVDS);
  c_ddr_cmos: cover property (boundary && cfg.mode == aof_pkg::MODE_DDR_CMOS);
  c_shift_inv: cover property (boundary && cfg.shift == 3'h7);
  c_saturate: cover property (boundary && core_under);

endmodule

// ===== core/aof_pkg.sv
// package: constants and types shared by the adc output formatter
package aof_pkg;

  // ==========================================================
  // sizes and phase timing
  localparam int SAMPLE_W = 14;
  localparam int PAIRS = 7;
  localparam int ADR_W = 8;
  // one sample period is eight clock phases, 45 degrees each
  localparam logic [2:0] PH_LAST = 3'h7;
  localparam logic [2:0] PH_MID = 3'h3;
  localparam logic [2:0] PH_HALF = 3'h4;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADR_W-1:0] CLK_CTL_OFS = 8'h00;
  localparam logic [ADR_W-1:0] OUT_MODE_OFS = 8'h04;
  localparam logic [ADR_W-1:0] FMT_OFS = 8'h08;
  localparam logic [ADR_W-1:0] STATUS_OFS = 8'h0c;

  // ==========================================================
  // field positions
  localparam int CC_PHASE_LSB = 0;
  localparam int CC_INV_BIT = 2;
  localparam int CC_DCS_BIT = 3;
  localparam int OM_MODE_LSB = 0;
  localparam int OM_CUR_LSB = 2;
  localparam int OM_TERM_BIT = 5;
  localparam int FM_TWOS_BIT = 0;
  localparam int FM_RAND_BIT = 1;
  localparam int FM_ABP_BIT = 2;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_PAR_BIT = 2;
  localparam int ST_OVR_BIT = 3;
  localparam int ST_DCS_BIT = 4;

  // ==========================================================
  // reset values and codes
  localparam logic [7:0] CLK_CTL_RST = 8'h00;
  localparam logic [7:0] OUT_MODE_RST = 8'h10;
  localparam logic [7:0] FMT_RST = 8'h00;
  localparam logic [1:0] MODE_CODE_FULL = 2'h0;
  localparam logic [1:0] MODE_CODE_DDR_CMOS = 2'h1;
  localparam logic [1:0] MODE_CODE_DDR_LVDS = 2'h2;
  localparam logic [2:0] CUR_SEL_DEFAULT = 3'h4;

  // lvds drive current in microamps per select code; code 7 falls back to default
  localparam logic [12:0] LVDS_UA [8] = '{13'h06d6, 13'h0834, 13'h09c4, 13'h0bb8,
                                         13'h0dac, 13'h0fa0, 13'h1194, 13'h0dac};
  localparam logic [15:0] TERM_MUL = 16'h0008;
  localparam logic [15:0] TERM_DIV = 16'h0005;

  // ==========================================================
  // sample codes
  localparam logic [SAMPLE_W-1:0] CODE_TOP = 14'h3fff;
  localparam logic [SAMPLE_W-1:0] CODE_BOTTOM = 14'h0000;
  localparam logic [SAMPLE_W-1:0] CODE_MID = 14'h2000;
  localparam logic [SAMPLE_W-1:0] ODD_MASK = 14'h2aaa;

  // ==========================================================
  // types
  typedef enum logic [1:0] {MODE_FULL_CMOS, MODE_DDR_CMOS, MODE_DDR_LVDS} aof_mode_e;

  typedef struct packed {
    aof_mode_e mode;
    logic [2:0] cur_sel;
    logic term;
    logic [2:0] shift;
    logic twos;
    logic rnd;
    logic abp;
  } aof_cfg_s;

  typedef struct packed {
    logic [SAMPLE_W-1:0] code;
    logic ovr;
    aof_mode_e mode;
    logic [2:0] shift;
    logic [12:0] ua;
    logic term;
  } aof_word_s;

endpackage

// ===== testbench/aof_rx_model.sv
// receiver model: captures the forwarded sample stream and undoes randomizer and alternate polarity
module aof_rx_model (
  input wire logic mclk, // system clock
  input wire logic reset_n, // sync reset, active low
  input wire logic [13:0] lines, // data lines
  input wire logic ovr_line, // overrange line
  input wire logic clk_p, // true forwarded clock
  input wire logic [1:0] mode, // active output mode
  input wire logic rnd, // randomizer in use
  input wire logic abp, // alternate polarity in use
  output logic [13:0] raw_word, // word as sent
  output logic [13:0] dec_word, // decoded word
  output logic raw_ovr, // captured flag
  output logic [15:0] word_cnt // words captured
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_p;
  logic [2:0] run;
  logic [2:0] cur_run;
  logic [13:0] lo_bits;
  logic [13:0] word;
  logic [13:0] dec;
  // ==========================================================
  // assemble and decode
  // cycles spent at the current clock level, saturating
  assign cur_run = (clk_p != prev_p) ? 3'h0 : ((run == 3'h7) ? run : run + 3'h1);
  // even bits while clock low, odd bits while high
  always_comb begin
    word = lo_bits;
    if (mode == 2'h1 || mode == 2'h2) begin
      for (int i = 0; i < 7; i++) begin
        word[2*i] = lo_bits[i];
        word[2*i+1] = lines[i];
      end
    end
    dec = word ^ (abp ? aof_pkg::ODD_MASK : 14'h0000);
    if (rnd) begin
      dec[13:1] = dec[13:1] ^ {13{dec[0]}};
    end
  end
  // ==========================================================
  // capture in the last cycle of each clock level
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prev_p <= 1'b0; // idle level of the forwarded clock after reset
      run <= 3'h0;
      lo_bits <= 14'h0000;
      raw_word <= 14'h0000;
      dec_word <= 14'h0000;
      raw_ovr <= 1'b0;
      word_cnt <= 16'h0000;
    end else begin
      prev_p <= clk_p;
      run <= cur_run;
      if (cur_run == 3'h3 && !clk_p) begin // latch before the rising edge
        lo_bits <= lines;
      end
      if (cur_run == 3'h3 && clk_p) begin
        raw_word <= word;
        dec_word <= dec;
        raw_ovr <= ovr_line;
        word_cnt <= word_cnt + 16'h0001;
      end
    end
  end
endmodule

// ===== testbench/tb_top.sv
// testbench: register access, sample formatting, output modes and clock phase
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic cfg_strap = 1'b0;
  logic mode_strap = 1'b0;
  logic [13:0] core_code = 14'h2000;
  logic core_over = 1'b0;
  logic core_under = 1'b0;
  logic [2:0] cur_fm = 3'h0;
  logic [31:0] wb_rdat, rd;
  logic wb_ack, core_take, ovr, clk_p, clk_n, term_en, dcs_en, rx_ovr;
  logic [13:0] sample_bits, rx_raw, rx_dec;
  logic [1:0] out_mode;
  logic [12:0] lvds_ua;
  logic [15:0] rx_cnt;
  logic [2:0] d, sh;
  int fail_count = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  // expected drive per current select, last entry is select 4 with termination
  localparam logic [12:0] UA_EXP [8] = '{13'h06d6, 13'h0834, 13'h09c4, 13'h0bb8,
                                        13'h0dac, 13'h0fa0, 13'h1194, 13'h15e0};

  aof_output_formatter u_dut (.mclk(mclk), .reset_n(reset_n), .ce(1'b1),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
    .config_style_strap(cfg_strap), .mode_strap(mode_strap), .core_code(core_code),
    .core_over(core_over), .core_under(core_under), .core_take(core_take),
    .sample_bits(sample_bits), .overrange_flag(ovr), .forwarded_data_clock_p(clk_p),
    .forwarded_data_clock_n(clk_n), .out_mode(out_mode), .lvds_drive_ua(lvds_ua),
    .lvds_term_en(term_en), .dcs_enable(dcs_en));

  aof_rx_model u_rx (.mclk(mclk), .reset_n(reset_n), .lines(sample_bits), .ovr_line(ovr),
    .clk_p(clk_p), .mode(out_mode), .rnd(cur_fm[1]), .abp(cur_fm[2]), .raw_word(rx_raw),
    .dec_word(rx_dec), .raw_ovr(rx_ovr), .word_cnt(rx_cnt));

  // ==========================================================
  // clock and hang guard
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      fail_count++;
      $display("FAIL %0t run did not finish in time", $time);
      tally_and_finish();
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dat,
                     input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge mclk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_sel <= sel;
    wb_wdat <= dat;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n == 20) begin
      fail_count++;
      $display("FAIL %0t no bus acknowledge", $time);
      tally_and_finish();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    bus(a, 1'b1, dat, 4'h1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, 4'hf);
    check(rd, exp, "register read");
  endtask

  task automatic wait_take();
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (core_take !== 1'b1 && n < 20);
    if (n == 20) begin
      fail_count++;
      $display("FAIL %0t no sample strobe", $time);
      tally_and_finish();
    end
  endtask

  // let a settings change reach the pins at a sample boundary
  task automatic next_sample();
    wait_take();
    wait_take();
    wait_take();
    @(posedge mclk);
  endtask

  function automatic logic [13:0] fmt_exp(input logic [13:0] c, input logic o,
                                          input logic u, input logic [2:0] fm);
    logic [13:0] v;
    v = o ? 14'h3fff : (u ? 14'h0000 : c);
    if (fm[0] && !fm[2]) v[13] = ~v[13];
    if (fm[1]) v[13:1] = v[13:1] ^ {13{v[0]}};
    if (fm[2]) v = v ^ aof_pkg::ODD_MASK;
    return v;
  endfunction

  // feed one sample and check the word the receiver captured for it
  task automatic run_sample(input logic [13:0] c, input logic o, input logic u);
    logic [15:0] tgt;
    wait_take();
    core_code <= c;
    core_over <= o;
    core_under <= u;
    tgt = rx_cnt + 16'h0004;
    // the run timeout ends this wait if the receiver stalls
    while (rx_cnt !== tgt) begin
      @(posedge mclk);
    end
    check(rx_raw, fmt_exp(c, o, u, cur_fm), "raw word");
    check(rx_dec, fmt_exp(c, o, u, {2'h0, cur_fm[0] & ~cur_fm[2]}), "decoded");
    check(rx_ovr, o | u, "overrange");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    check({lvds_ua, out_mode, clk_p, clk_n}, {13'h0dac, 2'h0, 2'b01}, "reset pins");
    rd_chk(aof_pkg::CLK_CTL_OFS, {24'h0, aof_pkg::CLK_CTL_RST});
    rd_chk(aof_pkg::OUT_MODE_OFS, {24'h0, aof_pkg::OUT_MODE_RST});
    rd_chk(aof_pkg::FMT_OFS, {24'h0, aof_pkg::FMT_RST});
    rd_chk(8'h10, 32'h0);
    wr(aof_pkg::STATUS_OFS, 32'hff);
    rd_chk(aof_pkg::STATUS_OFS, 32'h0);
    bus(aof_pkg::FMT_OFS, 1'b1, 32'h7, 4'h0);
    rd_chk(aof_pkg::FMT_OFS, 32'h0);
    $display("registers done");
    for (int m = 0; m < 3; m++) begin
      wr(aof_pkg::OUT_MODE_OFS, {24'h0, 3'h0, 3'h4, m[1:0]});
      for (int f = 0; f < 8; f++) begin
        wr(aof_pkg::FMT_OFS, {29'h0, f[2:0]});
        cur_fm <= f[2:0];
        run_sample({f[2:0], 10'h2c5, m[0]}, 1'b0, 1'b0);
      end
      check(out_mode, m[1:0], "output mode");
    end
    wr(aof_pkg::FMT_OFS, 32'h1);
    cur_fm <= 3'h1;
    run_sample(14'h1111, 1'b1, 1'b0);
    run_sample(14'h1111, 1'b0, 1'b1);
    run_sample(14'h2000, 1'b0, 1'b0);
    $display("formatting done");
    for (int s = 0; s < 8; s++) begin
      wr(aof_pkg::OUT_MODE_OFS, {26'h0, s == 7, (s == 7) ? 3'h4 : s[2:0], 2'h2});
      next_sample();
      check({lvds_ua, term_en}, {UA_EXP[s], s == 7}, "lvds drive");
    end
    $display("lvds drive done");
    wr(aof_pkg::OUT_MODE_OFS, 32'h10);
    for (int i = 0; i < 9; i++) begin
      wr(aof_pkg::CLK_CTL_OFS, (i == 8) ? 32'h2 : {29'h1, i[2:0]}); // dcs with shift, last pass sets phase without dcs
      next_sample();
      sh = (i == 8) ? 3'h0 : i[2:0];
      check(dcs_en, i != 8, "stabilizer");
      wait_take();
      for (int k = 0; k < 8; k++) begin
        @(posedge mclk);
        d = k[2:0] - sh;
        check({clk_p, clk_n}, {d[2], ~d[2]}, "clock level");
      end
    end
    wr(aof_pkg::CLK_CTL_OFS, 32'h0);
    $display("clock phase done");
    cfg_strap <= 1'b1;
    mode_strap <= 1'b1;
    cur_fm <= 3'h0;
    next_sample();
    check({out_mode, lvds_ua, term_en}, {2'h2, 13'h0dac, 1'b0}, "strap lvds");
    run_sample(14'h0abc, 1'b0, 1'b0);
    rd_chk(aof_pkg::STATUS_OFS, 32'h6);
    mode_strap <= 1'b0;
    next_sample();
    check(out_mode, 2'h0, "strap full rate");
    $display("strap done");
    tally_and_finish();
  end
endmodule
